/* File: acbd_pkg.sv */
`default_nettype none

package acbd_pkg;

  // Control byte geometry and field positions.
  localparam int CTRL_W = 8;
  localparam int START_POS = 7;
  localparam int SEL_HI_POS = 6;
  localparam int SEL_MID_POS = 5;
  localparam int SEL_LO_POS = 4;
  localparam int POLARITY_POS = 3;
  localparam int INPUT_CFG_POS = 2;
  localparam int POWER_POS = 1;
  localparam int CONV_CLK_POS = 0;

  // Bit counter of the serial receiver.
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_IDLE = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_FIRST = 4'h1;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST_BEFORE = 4'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_TRACK = 4'h6;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_HOLD = 4'h8;

  // Reset values of the captured control byte and of the result.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] RESULT_ZERO = 8'h00;

  // Channel index widths for the eight and four input variants.
  localparam int CHAN8_W = 3;
  localparam int CHAN4_W = 2;

endpackage

`default_nettype wire

/* File: acbd_link_if.sv */
`default_nettype none

// Carries the received control byte and the track state from the serial
// clock domain into the system clock domain.
interface acbd_link_if;
  import acbd_pkg::*;

  logic [CTRL_W-1:0] ctrl_byte;
  logic byte_toggle;
  logic track;

  modport rx
  (
    output ctrl_byte,
    output byte_toggle,
    output track
  );

  modport core
  (
    input ctrl_byte,
    input byte_toggle,
    input track
  );
endinterface

`default_nettype wire

/* File: acbd_serial_rx.sv */
`default_nettype none

module acbd_serial_rx
  import acbd_pkg::*;
(
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic rst_n_i,
  input wire logic din_i,
  output logic dout_o,
  acbd_link_if.rx link
);

  // Frame state is cleared whenever chip select is high or the block is reset.
  logic frame_rst;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [CTRL_W-1:0] shift_reg;
  logic idle;

  assign frame_rst = cs_n_i | ~rst_n_i;
  assign idle = (bit_cnt == BIT_CNT_IDLE) || (bit_cnt == BIT_CNT_HOLD);

  // ****************************************************************
  // Shift register and bit counter, rising serial clock edge.
  // ****************************************************************

  // Hunts for the start bit, then shifts in the seven remaining bits.
  always_ff @(posedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_cnt <= BIT_CNT_IDLE;
      shift_reg <= CTRL_RESET;
    end
    else if (idle)
    begin
      if (din_i)
      begin
        shift_reg <= {{(CTRL_W-1){1'b0}}, din_i};
        bit_cnt <= BIT_CNT_FIRST;
      end
      else
      begin
        bit_cnt <= BIT_CNT_IDLE;
      end
    end
    else
    begin
      shift_reg <= {shift_reg[CTRL_W-2:0], din_i};
      bit_cnt <= bit_cnt + BIT_CNT_FIRST;
    end
  end

  // Completed bytes and their toggle survive chip select so the crossing holds.
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.ctrl_byte <= CTRL_RESET;
      link.byte_toggle <= 1'b0;
    end
    else if (!cs_n_i && !idle && bit_cnt == BIT_CNT_LAST_BEFORE)
    begin
      link.ctrl_byte <= {shift_reg[CTRL_W-2:0], din_i};
      link.byte_toggle <= ~link.byte_toggle;
    end
  end

  // ****************************************************************
  // Falling edge logic: track/hold and serial data out.
  // ****************************************************************

  // Tracks after the sixth bit and holds after the eighth.
  always_ff @(negedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      link.track <= 1'b0;
    end
    else if (bit_cnt == BIT_CNT_TRACK)
    begin
      link.track <= 1'b1;
    end
    else if (bit_cnt == BIT_CNT_HOLD)
    begin
      link.track <= 1'b0;
    end
  end

  // Data out changes only on falling edges; no result framing here, so zeros.
  always_ff @(negedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      dout_o <= 1'b0;
    end
    else
    begin
      dout_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: acbd_top.sv */
`default_nettype none

// The serial receiver runs on the serial clock and hands each finished
// control byte over by a toggle, which is synchronised into the system
// clock domain before the byte is taken.
// The byte itself is not synchronised bit by bit: it stands still until the
// next byte is complete, at least eight serial clocks later, long after the toggle has crossed.
// Decoded fields come straight from the captured byte, so all of them
// change together in the cycle in which the valid pulse is raised.
// The result path lies wholly in the system clock domain and is only
// clamped, never reformatted.
// Framing of the result on the serial data out pin is not part of this block.
// The serial data out enable follows chip select without any register.

module acbd_top
  import acbd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [CTRL_W-1:0] conv_result_i,
  input wire logic conv_negative_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic [CHAN8_W-1:0] chan_sel_o,
  output logic polarity_select_o,
  output logic input_config_select_o,
  output logic power_state_select_o,
  output logic conv_clock_select_o,
  output logic [CHAN8_W-1:0] pos_chan8_o,
  output logic [CHAN8_W-1:0] neg_chan8_o,
  output logic [CHAN4_W-1:0] pos_chan4_o,
  output logic [CHAN4_W-1:0] neg_chan4_o,
  output logic neg_is_common_o,
  output logic ctrl_valid_o,
  output logic track_o,
  output logic [CTRL_W-1:0] result_o
);

  acbd_link_if link ();

  // Captured control byte, crossing flops and the decoded select bits.
  logic [CTRL_W-1:0] ctrl;
  logic toggle_meta;
  logic toggle_sync;
  logic toggle_seen;
  logic track_meta;
  logic new_byte;
  logic chan_sel_bit_hi;
  logic chan_sel_bit_mid;
  logic chan_sel_bit_lo;
  logic [CTRL_W-1:0] next_result;

  // ****************************************************************
  // Serial receiver in the serial clock domain.
  // ****************************************************************

  // Receiver of the control byte; it also owns the track/hold timing.
  acbd_serial_rx u_rx
  (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .rst_n_i(rst_n_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .link(link.rx)
  );

  // Data out is driven only while chip select is low.
  assign dout_oe_o = ~cs_n_i;

  // ****************************************************************
  // Clock domain crossing.
  // ****************************************************************

  // Byte toggle passes two flip-flops, then a third marks the change.
  // A change of the toggle is seen once, so each byte gives one pulse.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      toggle_meta <= 1'b0;
      toggle_sync <= 1'b0;
      toggle_seen <= 1'b0;
    end
    else
    begin
      toggle_meta <= link.byte_toggle;
      toggle_sync <= toggle_meta;
      toggle_seen <= toggle_sync;
    end
  end

  // A difference between the last two synchronised samples marks a new byte.
  assign new_byte = toggle_sync ^ toggle_seen;

  // Track state is a level and passes two flip-flops.
  // A short tracking window of two serial clocks still shows here.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      track_meta <= 1'b0;
      track_o <= 1'b0;
    end
    else
    begin
      track_meta <= link.track;
      track_o <= track_meta;
    end
  end

  // ****************************************************************
  // Control byte capture.
  // ****************************************************************

  // The byte is stable for at least eight serial clocks after its toggle.
  // Taking it while the toggle pulse stands therefore needs no other handshake.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (new_byte)
    begin
      ctrl <= link.ctrl_byte;
    end
  end

  // One-cycle pulse when a fresh control byte takes effect.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_valid_o <= 1'b0;
    end
    else
    begin
      ctrl_valid_o <= new_byte;
    end
  end

  // ****************************************************************
  // Field decode and channel routing.
  // ****************************************************************

  // Channel select bits.
  // Each bit is named on its own for the routing below.
  assign chan_sel_bit_hi = ctrl[SEL_HI_POS];
  assign chan_sel_bit_mid = ctrl[SEL_MID_POS];
  assign chan_sel_bit_lo = ctrl[SEL_LO_POS];
  assign chan_sel_o = ctrl[SEL_HI_POS:SEL_LO_POS];

  // Mode fields.
  // Reset leaves them all low: bipolar, differential, power-down, internal clock.
  assign polarity_select_o = ctrl[POLARITY_POS];
  assign input_config_select_o = ctrl[INPUT_CFG_POS];
  assign power_state_select_o = ctrl[POWER_POS];
  assign conv_clock_select_o = ctrl[CONV_CLK_POS];

  // Eight inputs: positive is the same code in both modes; in differential
  // mode the negative is the other member of the pair.
  // In single-ended mode the negative output is unused and the common pin is taken.
  assign pos_chan8_o = {chan_sel_bit_mid, chan_sel_bit_lo, chan_sel_bit_hi};
  assign neg_chan8_o = {chan_sel_bit_mid, chan_sel_bit_lo, ~chan_sel_bit_hi};
  assign neg_is_common_o = input_config_select_o;

  // Four inputs: the low select bit plays no part.
  // The pair is chosen by the middle bit and the member by the high bit.
  assign pos_chan4_o = {chan_sel_bit_mid, chan_sel_bit_hi};
  assign neg_chan4_o = {chan_sel_bit_mid, ~chan_sel_bit_hi};

  // ****************************************************************
  // Result clamp.
  // ****************************************************************

  // Negative differential input in unipolar mode reads as code zero.
  // Bipolar and single-ended results pass unchanged.
  always_comb
  begin
    next_result = conv_result_i;
    if (polarity_select_o && !input_config_select_o && conv_negative_i)
    begin
      next_result = RESULT_ZERO;
    end
  end

  // Registers the clamped result once per system clock.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_o <= RESULT_ZERO;
    end
    else
    begin
      result_o <= next_result;
    end
  end

endmodule

`default_nettype wire

/* File: acbd_master.sv */
`default_nettype none

// ****************************************
// Serial bus master model
// ****************************************
module acbd_master
(
  output var logic sclk_o = 1'b0,
  output var logic cs_n_o = 1'b1,
  output var logic din_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // Shifts z zeros and then n bits of a fresh byte, MSB first, in one select window.
  task automatic send(input logic [7:0] b, input int z, input int n);
    #3 cs_n_o = 1'b0;
    for (int i = 0; i < z + n; i++)
    begin
      din_o = (i < z) ? 1'b0 : b[7 - i + z];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
      if (i == z + 5)
        #1000;
    end
    #16 cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule

`default_nettype wire

/* File: acbd_assertions.sv */
`default_nettype none

// ****************************************
// Port checker of the decoder
// ****************************************
module acbd_checker
  import acbd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic [CTRL_W-1:0] conv_result_i,
  input wire logic conv_negative_i,
  input wire logic dout_oe_o,
  input wire logic [CHAN8_W-1:0] chan_sel_o,
  input wire logic polarity_select_o,
  input wire logic input_config_select_o,
  input wire logic power_state_select_o,
  input wire logic conv_clock_select_o,
  input wire logic [CHAN8_W-1:0] pos_chan8_o,
  input wire logic [CHAN8_W-1:0] neg_chan8_o,
  input wire logic [CHAN4_W-1:0] pos_chan4_o,
  input wire logic [CHAN4_W-1:0] neg_chan4_o,
  input wire logic neg_is_common_o,
  input wire logic ctrl_valid_o,
  input wire logic [CTRL_W-1:0] result_o
);
  // All checks run on the system clock.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_oe;
    dout_oe_o == !cs_n_i;
  endproperty
  a_oe: assert property (p_oe) else $error("data out enable wrong");
  property p_pos8;
    pos_chan8_o == {chan_sel_o[1:0], chan_sel_o[2]};
  endproperty
  a_pos8: assert property (p_pos8) else $error("positive channel wrong");
  property p_neg8;
    neg_chan8_o == {chan_sel_o[1:0], !chan_sel_o[2]};
  endproperty
  a_neg8: assert property (p_neg8) else $error("negative channel wrong");
  property p_ch4;
    {pos_chan4_o, neg_chan4_o} == {chan_sel_o[1], chan_sel_o[2], chan_sel_o[1], !chan_sel_o[2]};
  endproperty
  a_ch4: assert property (p_ch4) else $error("four input channels wrong");
  property p_common;
    neg_is_common_o == input_config_select_o;
  endproperty
  a_common: assert property (p_common) else $error("common pin select wrong");
  property p_pulse;
    ctrl_valid_o |=> !ctrl_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid pulse too long");
  property p_hold;
    !ctrl_valid_o |-> $stable({chan_sel_o, polarity_select_o, input_config_select_o,
      power_state_select_o, conv_clock_select_o});
  endproperty
  a_hold: assert property (p_hold) else $error("fields moved without byte");
  property p_result;
    $past(rst_n_i) |-> result_o == (($past(polarity_select_o) && !$past(input_config_select_o)
      && $past(conv_negative_i)) ? 8'h00 : $past(conv_result_i));
  endproperty
  a_result: assert property (p_result) else $error("result wrong");
endmodule

bind acbd_top acbd_checker chk
(
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .conv_result_i(conv_result_i),
  .conv_negative_i(conv_negative_i), .dout_oe_o(dout_oe_o), .chan_sel_o(chan_sel_o),
  .polarity_select_o(polarity_select_o), .input_config_select_o(input_config_select_o),
  .power_state_select_o(power_state_select_o), .conv_clock_select_o(conv_clock_select_o),
  .pos_chan8_o(pos_chan8_o), .neg_chan8_o(neg_chan8_o), .pos_chan4_o(pos_chan4_o),
  .neg_chan4_o(neg_chan4_o), .neg_is_common_o(neg_is_common_o),
  .ctrl_valid_o(ctrl_valid_o), .result_o(result_o)
);

`default_nettype wire

/* File: adc_control_byte_decoder_bench.sv */
`default_nettype none

// ****************************************
// Bench of the control byte decoder
// ****************************************
module adc_control_byte_decoder_bench import acbd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic [CTRL_W-1:0] conv_result_i = 8'h00;
  logic conv_negative_i = 1'b0;
  logic sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, neg_is_common_o, ctrl_valid_o, track_o;
  logic polarity_select_o, input_config_select_o, power_state_select_o, conv_clock_select_o;
  logic [CHAN8_W-1:0] chan_sel_o, pos_chan8_o, neg_chan8_o;
  logic [CHAN4_W-1:0] pos_chan4_o, neg_chan4_o;
  logic [CTRL_W-1:0] result_o, exp_res;
  logic armed = 1'b0;
  logic [CTRL_W-1:0] sent_byte = 8'h00;
  logic [CTRL_W-1:0] model_byte = 8'h00;
  int n_valid = 0;
  int n_fail = 0;
  int samples_checked = 0;
  int n_track = 0;

  // The system clock toggles every half period.
  always #4 mclk_i = ~mclk_i;

  acbd_top dut
  (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
    .conv_result_i(conv_result_i), .conv_negative_i(conv_negative_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .chan_sel_o(chan_sel_o), .polarity_select_o(polarity_select_o),
    .input_config_select_o(input_config_select_o),
    .power_state_select_o(power_state_select_o), .conv_clock_select_o(conv_clock_select_o),
    .pos_chan8_o(pos_chan8_o), .neg_chan8_o(neg_chan8_o), .pos_chan4_o(pos_chan4_o),
    .neg_chan4_o(neg_chan4_o), .neg_is_common_o(neg_is_common_o),
    .ctrl_valid_o(ctrl_valid_o), .track_o(track_o), .result_o(result_o)
  );
  acbd_master m (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  // Compares every decoded field against the byte last sent whole.
  task automatic expect_fields(input logic [7:0] b);
    check("chan_sel", b[6:4], chan_sel_o);
    check("polarity", b[3], polarity_select_o);
    check("input_cfg", b[2], input_config_select_o);
    check("power", b[1], power_state_select_o);
    check("conv_clk", b[0], conv_clock_select_o);
    check("pos8", b[5] * 4 + b[4] * 2 + b[6], pos_chan8_o);
    check("neg8", (b[5] * 2 + b[4]) * 2 + !b[6], neg_chan8_o);
    check("pos4", b[5] * 2 + b[6], pos_chan4_o);
    check("neg4", b[5] * 2 + !b[6], neg_chan4_o);
    check("neg_common", b[2], neg_is_common_o);
    check("dout", 8'h00, dout_o);
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Counts track windows seen by the system clock side.
  always @(posedge track_o) n_track++;

  // Drives random converter results and checks the clamped result one cycle later.
  always @(posedge mclk_i)
  begin
    if (armed && rst_n_i)
      check("result", exp_res, result_o);
    if (ctrl_valid_o)
    begin
      model_byte = sent_byte;
      n_valid++;
    end
    exp_res <= (model_byte[POLARITY_POS] && !model_byte[INPUT_CFG_POS] && conv_negative_i)
      ? 8'h00 : conv_result_i;
    armed <= rst_n_i;
    conv_result_i <= 8'($urandom);
    conv_negative_i <= 1'($urandom);
  end

  // Sends bytes over every channel code with leading zeros and aborted frames between.
  initial
  begin
    logic [7:0] b;
    rst_n_i <= 1'b0;
    void'($urandom(32'ha7fb_2b25));
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    m.send(8'h00, 0, 0);
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 24; i++)
    begin
      b = {1'b1, i[2:0], 4'($urandom)};
      b[2] = b[2] & b[3];
      sent_byte = b;
      m.send(b, i % 4, 8);
      if (i % 5 == 4)
        m.send(8'hff, 0, 5);
      repeat (6) @(posedge mclk_i);
      expect_fields(b);
    end
    check("track_pulses", 8'h18, 8'(n_track));
    check("valid_pulses", 8'h18, 8'(n_valid));
    conclude();
  end

  // Cuts a hung run short.
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
